// ===== rtl/data_move_regs.svh
// constants for the data move execution block
// assumes inclusion by bare name from rtl files
`ifndef DATA_MOVE_REGS_SVH
`define DATA_MOVE_REGS_SVH
`define ACC_RESET 8'h00
`define FLAGS_RESET 4'h0
`define FLAG_Z 0
`define FLAG_C 1
`define FLAG_AC 2
`define FLAG_OV 3
`define BIT_ADDR_MAX 9'h03F
`define MEM_ADDR_W 9
`define IO_ADDR_W 6
`endif

// ===== rtl/data_move_pkg.sv
// types shared by the data move execution block
// assumes a one-cycle execute slot per instruction except word ops, which take two
package data_move_pkg;
  typedef enum logic [3:0]
  {
    OP_NONE = 4'h0,
    OP_MOV_IMM = 4'h1,
    OP_MOV_STORE = 4'h2,
    OP_MOV_LOAD = 4'h3,
    OP_IO_READ = 4'h4,
    OP_IO_WRITE = 4'h5,
    OP_TIMER_TO_MEM = 4'h6,
    OP_MEM_TO_TIMER = 4'h7,
    OP_BIT_MEM = 4'h8,
    OP_ALU_UPDATE = 4'h9
  } op_e;
  typedef struct packed
  {
    logic ov;
    logic ac;
    logic c;
    logic z;
  } flags_s;
  typedef struct packed
  {
    op_e op;
    logic [8:0] addr;
    logic [7:0] imm;
  } instr_s;
endpackage

// ===== rtl/flag_calc.sv
// flag computation for an 8-bit add or subtract
// assumes operands are stable in the execute cycle
`timescale 1ns/1ps
module flag_calc
(
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic sub,
  output logic [7:0] result,
  output data_move_pkg::flags_s flags
);
  import data_move_pkg::*;
  logic [8:0] full;
  logic [4:0] low;
  logic [7:0] bx;
  always_comb
  begin
    bx = sub ? ~b : b;
    full = {1'b0, a} + {1'b0, bx} + {8'h00, sub};
    low = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, sub};
    result = full[7:0];
    flags.z = (full[7:0] == 8'h00);
    flags.c = sub ? ~full[8] : full[8];
    flags.ac = sub ? ~low[4] : low[4];
    flags.ov = (a[7] == bx[7]) && (full[7] != a[7]);
  end
endmodule

// ===== rtl/data_move_instruction_exec.sv
// execute stage for data transfer instructions of an 8-bit core
// assumes decoded instructions arrive one per cycle with instr_valid
`timescale 1ns/1ps
`include "data_move_regs.svh"
module data_move_instruction_exec
#(
  parameter int MEM_DEPTH = 512
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic instr_valid,
  input data_move_pkg::instr_s instr,
  input wire logic alu_sub,
  input wire logic [7:0] alu_operand,
  input wire logic [15:0] sixteen_bit_timer,
  input wire logic [7:0] io_rdata,
  output logic [7:0] accumulator,
  output data_move_pkg::flags_s flags,
  output logic [`IO_ADDR_W-1:0] io_addr,
  output logic [7:0] io_wdata,
  output logic io_we,
  output logic [15:0] timer_load_value,
  output logic timer_load,
  output logic bit_addr_error,
  output logic [7:0] mem_rdata,
  output logic busy
);
  import data_move_pkg::*;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b01,
    ST_HIGH = 2'b10
  } state_e;
  logic [7:0] mem [MEM_DEPTH];
  state_e state_q;
  logic [7:0] acc_q;
  flags_s flags_q;
  logic [8:0] word_addr_q;
  logic [7:0] hold_q;
  logic [7:0] alu_res;
  flags_s alu_flags;
  logic [7:0] rd_byte;
  logic take;
  logic timer_dir_q;
  logic [7:0] hold_lo_q;

  function automatic logic bit_addr_ok(input logic [8:0] a);
    bit_addr_ok = (a <= `BIT_ADDR_MAX);
  endfunction

  flag_calc u_flag_calc
  (
    .a(acc_q),
    .b(alu_operand),
    .sub(alu_sub),
    .result(alu_res),
    .flags(alu_flags)
  );

  // word ops take two cycles; new instructions wait
  assign take = instr_valid && (state_q == ST_IDLE);
  assign rd_byte = mem[instr.addr];

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_IDLE;
      word_addr_q <= 9'h000;
      hold_q <= 8'h00;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (take && (instr.op == OP_TIMER_TO_MEM
              || instr.op == OP_MEM_TO_TIMER))
          begin
            state_q <= ST_HIGH;
            word_addr_q <= instr.addr;
            hold_q <= sixteen_bit_timer[15:8];
          end
        end
        ST_HIGH:
          state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // memory array has no reset: contents undefined until written
  always_ff @(posedge ref_clk)
  begin
    if (take && instr.op == OP_MOV_STORE)
      mem[instr.addr] <= acc_q;
    if (take && instr.op == OP_TIMER_TO_MEM)
      mem[instr.addr] <= sixteen_bit_timer[7:0];
    if (state_q == ST_HIGH && !timer_dir_q)
      mem[word_addr_q + 9'h001] <= hold_q;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      timer_dir_q <= 1'b0;
    else if (take)
      timer_dir_q <= (instr.op == OP_MEM_TO_TIMER);
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_q <= `ACC_RESET;
      flags_q <= `FLAGS_RESET;
    end
    else if (take)
    begin
      case (instr.op)
        OP_MOV_IMM:
          acc_q <= instr.imm;
        OP_MOV_LOAD:
        begin
          acc_q <= rd_byte;
          flags_q.z <= (rd_byte == 8'h00);
        end
        OP_IO_READ:
        begin
          acc_q <= io_rdata;
          flags_q.z <= (io_rdata == 8'h00);
        end
        OP_ALU_UPDATE:
        begin
          acc_q <= alu_res;
          flags_q <= alu_flags;
        end
        default:
          acc_q <= acc_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      io_addr <= '0;
      io_wdata <= 8'h00;
      io_we <= 1'b0;
    end
    else
    begin
      io_we <= take && instr.op == OP_IO_WRITE;
      io_wdata <= acc_q;
      io_addr <= instr.addr[`IO_ADDR_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      timer_load <= 1'b0;
      timer_load_value <= 16'h0000;
      hold_lo_q <= 8'h00;
    end
    else
    begin
      if (take && instr.op == OP_MEM_TO_TIMER)
        hold_lo_q <= rd_byte;
      timer_load <= (state_q == ST_HIGH) && timer_dir_q;
      if ((state_q == ST_HIGH) && timer_dir_q)
        timer_load_value <= {mem[word_addr_q + 9'h001], hold_lo_q};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bit_addr_error <= 1'b0;
      mem_rdata <= 8'h00;
    end
    else
    begin
      bit_addr_error <= take && instr.op == OP_BIT_MEM
        && !bit_addr_ok(instr.addr);
      mem_rdata <= rd_byte;
    end
  end

  assign accumulator = acc_q;
  assign flags = flags_q;
  // one-hot: bit 1 is the second word cycle, so busy is a plain flop
  assign busy = state_q[1];
endmodule

// ===== tb/data_move_exec_sva.sv
// assertions for the data move execution block
// assumes binding onto the ports of its top module
`timescale 1ns/1ps
module data_move_exec_sva
import data_move_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic instr_valid,
  input data_move_pkg::instr_s instr,
  input wire logic [7:0] io_rdata,
  input wire logic [7:0] accumulator,
  input data_move_pkg::flags_s flags,
  input wire logic [7:0] io_wdata,
  input wire logic io_we,
  input wire logic timer_load,
  input wire logic bit_addr_error,
  input wire logic busy
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // refused while busy, so only taken slots count
  wire take = instr_valid && !busy;
  a_imm_acc: assert property (
    take && instr.op == OP_MOV_IMM |=>
    accumulator == $past(instr.imm) && flags == $past(flags))
    else $error("imm move");
  a_store_flags: assert property (
    take && instr.op == OP_MOV_STORE |=> $stable(flags))
    else $error("store flags");
  a_load_zero: assert property (
    take && instr.op == OP_MOV_LOAD |=>
    flags.z == (accumulator == 8'h00) && flags[3:1] == $past(flags[3:1]))
    else $error("load flags");
  a_io_read: assert property (
    take && instr.op == OP_IO_READ |=>
    accumulator == $past(io_rdata) && flags.z == (accumulator == 8'h00))
    else $error("io read");
  a_io_write: assert property (
    take && instr.op == OP_IO_WRITE |=>
    io_we && io_wdata == $past(accumulator) && $stable(flags))
    else $error("io write");
  a_word_store: assert property (
    take && instr.op == OP_TIMER_TO_MEM |=>
    busy ##1 !busy && flags == $past(flags, 2))
    else $error("word store");
  a_word_load: assert property (
    take && instr.op == OP_MEM_TO_TIMER |=>
    busy && !timer_load ##1 timer_load)
    else $error("timer load");
  a_bit_range: assert property (
    take && instr.op == OP_BIT_MEM |=>
    bit_addr_error == ($past(instr.addr) > 9'h03F))
    else $error("bit range");
endmodule
bind data_move_instruction_exec data_move_exec_sva u_sva (.ref_clk(ref_clk),
  .resetn(resetn), .instr_valid(instr_valid), .instr(instr),
  .io_rdata(io_rdata), .accumulator(accumulator), .flags(flags),
  .io_wdata(io_wdata), .io_we(io_we), .timer_load(timer_load),
  .bit_addr_error(bit_addr_error), .busy(busy));

// ===== tb/data_move_instruction_exec_tb.sv
// self-checking bench for the data move execution block
// assumes the bench alone drives all inputs at the falling edge
`timescale 1ns/1ps
`define CHK(g,e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module data_move_instruction_exec_tb;
  import data_move_pkg::*;
  logic ref_clk = 0, resetn = 0, instr_valid = 0, alu_sub = 0, err;
  logic timer_load, busy, bit_err;
  logic [5:0] io_addr;
  logic [7:0] io_wdata, mem_rdata;
  logic io_we, we;
  instr_s instr = '0;
  logic [7:0] alu_operand = 8'h00, io_rdata = 8'h00, accumulator;
  logic [15:0] sixteen_bit_timer = 16'h0000, tval;
  logic [8:0] ba[2] = '{9'h03F, 9'h040};
  flags_s flags;
  int failures = 0, n_compared = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  data_move_instruction_exec u_data_move_instruction_exec (.ref_clk(ref_clk),
    .resetn(resetn), .instr_valid(instr_valid), .instr(instr),
    .alu_sub(alu_sub), .alu_operand(alu_operand),
    .sixteen_bit_timer(sixteen_bit_timer), .io_rdata(io_rdata),
    .accumulator(accumulator), .flags(flags), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_we(io_we), .timer_load_value(tval),
    .timer_load(timer_load), .bit_addr_error(bit_err),
    .mem_rdata(mem_rdata), .busy(busy));
  task automatic conclude();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // word ops hold busy one cycle, so two idle cycles follow each slot
  task automatic run(op_e o, logic [8:0] a, logic [7:0] i);
    instr_valid = 1;
    instr = '{o, a, i};
    @(negedge ref_clk);
    instr_valid = 0;
    err = bit_err;
    we = io_we;
    repeat (2) @(negedge ref_clk);
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      failures++;
      conclude();
    end
  end
  initial
  begin
    repeat (2) @(negedge ref_clk);
    resetn = 1;
    run(OP_MOV_IMM, 9'h010, 8'hA5);
    `CHK(accumulator, 8'hA5)
    run(OP_MOV_STORE, 9'h010, 8'h00);
    run(OP_MOV_IMM, 9'h000, 8'h00);
    run(OP_MOV_STORE, 9'h011, 8'h00);
    run(OP_MOV_LOAD, 9'h010, 8'h00);
    `CHK({accumulator, flags, mem_rdata}, 20'hA50A5)
    run(OP_MOV_LOAD, 9'h011, 8'h00);
    `CHK(flags, 4'h1)
    io_rdata = 8'h3C;
    run(OP_IO_READ, 9'h005, 8'h00);
    `CHK({accumulator, flags}, 12'h3C0)
    $display("moves done");
    alu_operand = 8'h44;
    run(OP_ALU_UPDATE, 9'h000, 8'h00);
    `CHK({accumulator, flags}, 12'h80C)
    alu_sub = 1;
    alu_operand = 8'h81;
    run(OP_ALU_UPDATE, 9'h000, 8'h00);
    `CHK(flags.c, 1'b1)
    run(OP_IO_WRITE, 9'h03F, 8'h00);
    `CHK(flags.c, 1'b1)
    `CHK({we, io_addr, io_wdata}, 15'h7FFF)
    $display("flags done");
    sixteen_bit_timer = 16'h1234;
    run(OP_TIMER_TO_MEM, 9'h020, 8'h00);
    sixteen_bit_timer = 16'h0000;
    run(OP_MOV_LOAD, 9'h021, 8'h00);
    `CHK(accumulator, 8'h12)
    run(OP_MEM_TO_TIMER, 9'h020, 8'h00);
    `CHK(tval, 16'h1234)
    foreach (ba[k])
    begin
      run(OP_BIT_MEM, ba[k], 8'h00);
      `CHK(err, k[0])
    end
    $display("words done");
    conclude();
  end
endmodule
